//--- board_model.sv
// Board side: resolves the shared pins and drives lines the device releases
`timescale 1ns/1ps
module board_model (
   input wire logic [31:0] data_pin_out,
   input wire logic [31:0] data_pin_oe_n,
   input wire logic [31:0] board_data,
   output logic [31:0] data_pin_in,
   input wire logic clock_pin_out,
   input wire logic clock_pin_oe_n,
   input wire logic run_low,
   output logic clock_pin_in,
   input wire logic [3:0] flag_pin_out,
   input wire logic [3:0] flag_pin_oe_n,
   output logic [3:0] flag_pin_in
);
   // Driven lines carry the device value, released ones the board value
   assign data_pin_in = (data_pin_out & ~data_pin_oe_n) | (board_data & data_pin_oe_n);
   // Pulled-up clock/reset line; the board may pull it low as running reset
   assign clock_pin_in = !clock_pin_oe_n ? clock_pin_out : !run_low;
   // Board holds a fixed pattern on released flag lines
   assign flag_pin_in = (flag_pin_out & ~flag_pin_oe_n) | (4'h9 & flag_pin_oe_n);
endmodule

//--- pin_sync.sv
// Three-stage pin input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
   parameter int width = 8
) (
   input wire logic clk,
   input wire logic [width-1:0] pin,
   output logic [width-1:0] level
);

   // ****************************************************************
   // Storage
   // ****************************************************************
   typedef struct packed {
      logic [width-1:0] s1; // First stage, read by s2 only
      logic [width-1:0] s2; // Second stage
      logic [width-1:0] s3; // Third stage
      logic [width-1:0] level; // Accepted level
   } sync_t;

   sync_t r;
   sync_t next_r;

   // Shift and accept a bit once stages two and three agree
   always_comb begin
      next_r = r;
      next_r.s1 = pin;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      for (int i = 0; i < width; i++) begin
         if (r.s2[i] == r.s3[i]) begin
            next_r.level[i] = r.s3[i];
         end
      end
   end

   // No reset so that straps flow through while reset is held
   always_ff @(posedge clk) begin
      r <= next_r;
   end

   assign level = r.level;

endmodule

//--- strap_pin_mux.sv
// Start-up strap capture, PLL lock wait and pin function multiplexer
// Behaviour
// - Modes 000-011 place port data and flags
// - Modes 100/101 route acquisition port inputs
// - Mode 110 reserved, 111 tri-states pins
// - Flag/PWM choice changes in groups of four
// - Boot straps: slave, master, external memory
// - Ratio straps select 6, 32 or 16
// - Software multiplier/divider write overrides strap ratio
// - Wait 4096 reference cycles after reset release
// - Then core starts at reset vector
// - Clock pin: reset out, bit 12 clock
// - Running reset bit 0 makes pin input
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module strap_pin_mux #(
   parameter int lock_wait = strap_pin_pkg::lock_cycles,
   parameter logic [31:0] vector = strap_pin_pkg::reset_vector
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [1:0] boot_strap_pins,
   input wire logic [1:0] core_ratio_strap_pins,
   output logic [1:0] boot_mode,
   output logic [5:0] pll_multiplier,
   output logic [1:0] pll_divider,
   output logic core_run,
   output logic fetch_start,
   output logic [31:0] fetch_address,
   input wire logic pll_clock_level,
   input wire logic clock_pin_in,
   output logic clock_pin_out,
   output logic clock_pin_oe_n,
   output logic running_reset,
   input wire logic [3:0] flag_pin_in,
   output logic [3:0] flag_pin_out,
   output logic [3:0] flag_pin_oe_n,
   input wire logic [31:0] data_pin_in,
   output logic [31:0] data_pin_out,
   output logic [31:0] data_pin_oe_n,
   input wire logic [31:0] external_port_data_out,
   input wire logic external_port_data_drive,
   output logic [31:0] external_port_data_in,
   input wire logic [15:0] upper_flag_out,
   input wire logic [15:0] upper_flag_drive,
   input wire logic [15:0] pwm_out,
   input wire logic [15:0] lower_flag_out,
   input wire logic [15:0] lower_flag_drive,
   output logic [23:0] parallel_acquisition_port,
   output logic [2:0] data_mode
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic waitrequest; // Bus stall, high while idle
      logic [31:0] readdata; // Bus read data
      logic [2:0] mode; // Data pin mode
      logic [3:0] group_pwm; // Per group of four: 1 selects PWM
      logic [5:0] mult; // Active multiplier
      logic [1:0] div; // Active divider
      logic clk_sel; // Pin drives PLL clock
      logic override; // Software has set the ratio
      logic run_reset_en; // Pin is running reset input
      logic [3:0] flag_out; // Flag output levels
      logic [3:0] flag_drive; // Flag output enables
      logic captured; // Straps taken since release
      logic [1:0] boot; // Latched boot code
      logic [1:0] ratio; // Latched ratio code
      logic [12:0] lock_cnt; // PLL lock wait counter
      logic locked; // Lock wait complete
      logic core_run; // Core allowed to execute
      logic fetch_start; // One-cycle start pulse
      logic running_reset; // Running reset held by pin
      logic clk_out; // Clock pin level
      logic clk_oe_n; // Clock pin enable, low drives
      logic [3:0] flag_pin_oe_n; // Flag pin enables, low drives
      logic [31:0] data_out; // Data pin levels
      logic [31:0] data_oe_n; // Data pin enables, low drives
      logic [23:0] acq; // Acquisition port capture
   } state_t;

   state_t r;
   state_t next_r;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [40:0] synced; // Straps, flags, clock pin and data after filtering

   pin_sync #(
      .width(41)
   ) u_sync (
      .clk(clk),
      .pin({boot_strap_pins, core_ratio_strap_pins, flag_pin_in, clock_pin_in, data_pin_in}),
      .level(synced)
   );

   logic [1:0] boot_sync; // Boot strap level
   logic [1:0] ratio_sync; // Ratio strap level
   logic [3:0] flag_sync; // Flag pin levels
   logic clock_pin_sync; // Running reset pin level
   logic [31:0] data_sync; // Data pin levels

   assign boot_sync = synced[40:39];
   assign ratio_sync = synced[38:37];
   assign flag_sync = synced[36:33];
   assign clock_pin_sync = synced[32];
   assign data_sync = synced[31:0];

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   logic access; // Bus request in its answer cycle
   logic [5:0] strap_mult; // Multiplier decoded from ratio straps

   // Decode ratio straps; reserved code keeps the lowest ratio
   always_comb begin
      unique case (ratio_sync)
         strap_pin_pkg::ratio_code_32: strap_mult = strap_pin_pkg::mult_32;
         strap_pin_pkg::ratio_code_16: strap_mult = strap_pin_pkg::mult_16;
         default: strap_mult = strap_pin_pkg::mult_6;
      endcase
   end

   // Bus, configuration, start-up sequence and pin steering
   always_comb begin
      next_r = r;
      access = (avs_read || avs_write) && !r.waitrequest;
      next_r.fetch_start = 1'b0;

      // Bus answer: drop waitrequest one cycle after a request appears
      if (access) begin
         next_r.waitrequest = 1'b1;
      end else if (avs_read || avs_write) begin
         next_r.waitrequest = 1'b0;
      end
      // Read data stands for the answer cycle only
      next_r.readdata = 32'h0000_0000;
      // Capture read data as the request is taken
      if ((avs_read) && r.waitrequest) begin
         unique case (avs_address)
            strap_pin_pkg::off_system_control: begin
               next_r.readdata[strap_pin_pkg::mode_lsb +: 3] = r.mode;
               next_r.readdata[strap_pin_pkg::group_lsb +: 4] = r.group_pwm;
            end
            strap_pin_pkg::off_power_management: begin
               next_r.readdata[strap_pin_pkg::mult_lsb +: 6] = r.mult;
               next_r.readdata[strap_pin_pkg::div_lsb +: 2] = r.div;
               next_r.readdata[strap_pin_pkg::clk_sel_bit] = r.clk_sel;
            end
            strap_pin_pkg::off_running_reset: begin
               next_r.readdata[strap_pin_pkg::run_reset_bit] = r.run_reset_en;
            end
            strap_pin_pkg::off_flag_control: begin
               next_r.readdata[strap_pin_pkg::flag_out_lsb +: 4] = r.flag_out;
               next_r.readdata[strap_pin_pkg::flag_drive_lsb +: 4] = r.flag_drive;
            end
            // Status is built from live state
            strap_pin_pkg::off_status: begin
               next_r.readdata = {19'h00000, r.override, flag_sync, r.running_reset,
                  r.core_run, r.locked, (r.boot == strap_pin_pkg::strap_reserved) ||
                  (r.ratio == strap_pin_pkg::strap_reserved), r.ratio, r.boot};
            end
            default: next_r.readdata = 32'h0000_0000;
         endcase
      end

      // Register writes take effect at the answer edge
      if (access && avs_write) begin
         unique case (avs_address)
            strap_pin_pkg::off_system_control: begin
               next_r.mode = avs_writedata[strap_pin_pkg::mode_lsb +: 3];
               next_r.group_pwm = avs_writedata[strap_pin_pkg::group_lsb +: 4];
            end
            strap_pin_pkg::off_power_management: begin
               next_r.mult = avs_writedata[strap_pin_pkg::mult_lsb +: 6];
               next_r.div = avs_writedata[strap_pin_pkg::div_lsb +: 2];
               next_r.clk_sel = avs_writedata[strap_pin_pkg::clk_sel_bit];
               next_r.override = 1'b1;
            end
            strap_pin_pkg::off_running_reset: begin
               next_r.run_reset_en = avs_writedata[strap_pin_pkg::run_reset_bit];
            end
            strap_pin_pkg::off_flag_control: begin
               next_r.flag_out = avs_writedata[strap_pin_pkg::flag_out_lsb +: 4];
               next_r.flag_drive = avs_writedata[strap_pin_pkg::flag_drive_lsb +: 4];
            end
            // Unmapped and read-only offsets ignored
            default: begin
               next_r.mode = r.mode;
            end
         endcase
      end

      // Latch straps at the first edge after reset release
      if (!r.captured) begin
         next_r.captured = 1'b1;
         next_r.boot = boot_sync;
         next_r.ratio = ratio_sync;
         // A software ratio survives capture
         if (!r.override) begin
            next_r.mult = strap_mult;
         end
      end

      // Count reference cycles for PLL lock, then let the core run
      if (!r.locked) begin
         if (r.lock_cnt == 13'(lock_wait - 1)) begin
            next_r.locked = 1'b1;
         end
         next_r.lock_cnt = r.lock_cnt + 13'h0001;
      end
      // Running reset follows the filtered pin
      next_r.running_reset = r.run_reset_en && !clock_pin_sync;
      next_r.core_run = r.locked && !r.running_reset;
      // Start pulse as the core is released
      if (r.locked && !r.running_reset && !r.core_run) begin
         next_r.fetch_start = 1'b1;
      end

      // Multi-purpose clock pin: input, PLL clock or reset out
      if (r.run_reset_en) begin
         next_r.clk_oe_n = 1'b1;
         next_r.clk_out = 1'b0;
      end else if (r.clk_sel) begin
         next_r.clk_oe_n = 1'b0;
         next_r.clk_out = pll_clock_level;
      end else begin
         next_r.clk_oe_n = 1'b0;
         next_r.clk_out = r.core_run;
      end

      // Flag pins stay released until software enables a driver
      next_r.flag_pin_oe_n = ~r.flag_drive;

      // Data pin steering per bit
      for (int i = 0; i < 32; i++) begin
         next_r.data_out[i] = external_port_data_out[i];
         next_r.data_oe_n[i] = !external_port_data_drive;
         unique case (r.mode)
            strap_pin_pkg::mode_port_all: begin
               next_r.data_oe_n[i] = !external_port_data_drive;
            end
            strap_pin_pkg::mode_flags_upper, strap_pin_pkg::mode_flags_mid,
            strap_pin_pkg::mode_flags_all: begin
               // Upper half: flag or PWM per group
               if (i >= 16) begin
                  if (r.group_pwm[(i - 16) / 4]) begin
                     next_r.data_out[i] = pwm_out[i - 16];
                     next_r.data_oe_n[i] = 1'b0;
                  end else begin
                     next_r.data_out[i] = upper_flag_out[i - 16];
                     next_r.data_oe_n[i] = !upper_flag_drive[i - 16];
                  end
               end else if ((i >= 8 && r.mode != strap_pin_pkg::mode_flags_upper) ||
                  r.mode == strap_pin_pkg::mode_flags_all) begin
                  next_r.data_out[i] = lower_flag_out[i];
                  next_r.data_oe_n[i] = !lower_flag_drive[i];
               end
            end
            // Acquisition pins are inputs only
            strap_pin_pkg::mode_acq_port, strap_pin_pkg::mode_acq_flags: begin
               if (i >= 8) begin
                  next_r.data_out[i] = 1'b0;
                  next_r.data_oe_n[i] = 1'b1;
               end else if (r.mode == strap_pin_pkg::mode_acq_flags) begin
                  next_r.data_out[i] = lower_flag_out[i];
                  next_r.data_oe_n[i] = !lower_flag_drive[i];
               end
            end
            // Reserved code acts as tri-state
            strap_pin_pkg::mode_reserved, strap_pin_pkg::mode_tristate: begin
               next_r.data_out[i] = 1'b0;
               next_r.data_oe_n[i] = 1'b1;
            end
         endcase
      end

      // Acquisition port sees pins 31-8 only in its modes
      if (r.mode == strap_pin_pkg::mode_acq_port || r.mode == strap_pin_pkg::mode_acq_flags) begin
         next_r.acq = data_sync[31:8];
      end else begin
         next_r.acq = 24'h000000;
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   // Asynchronous reset loads constants only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // Clear all, then non-zero values
         r <= '0;
         r.waitrequest <= 1'b1;
         r.mode <= strap_pin_pkg::mode_reset;
         r.mult <= strap_pin_pkg::mult_6;
         r.div <= strap_pin_pkg::div_reset;
         r.clk_oe_n <= 1'b0;
         r.flag_pin_oe_n <= 4'hf;
         r.data_oe_n <= 32'hffff_ffff;
      end else begin
         r <= next_r;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign avs_readdata = r.readdata;
   assign avs_waitrequest = r.waitrequest;
   assign boot_mode = r.boot;
   assign pll_multiplier = r.mult;
   assign pll_divider = r.div;
   assign core_run = r.core_run;
   assign fetch_start = r.fetch_start;
   assign fetch_address = vector;
   assign clock_pin_out = r.clk_out;
   assign clock_pin_oe_n = r.clk_oe_n;
   assign running_reset = r.running_reset;
   assign flag_pin_out = r.flag_out;
   assign flag_pin_oe_n = r.flag_pin_oe_n;
   assign data_pin_out = r.data_out;
   assign data_pin_oe_n = r.data_oe_n;
   assign external_port_data_in = data_sync;
   assign parallel_acquisition_port = r.acq;
   assign data_mode = r.mode;

endmodule

//--- strap_pin_mux_checker.sv
// Port-level assertions for the strap and pin function multiplexer
`timescale 1ns/1ps
module strap_pin_mux_checker #(
   parameter int lock_wait = 16,
   parameter logic [31:0] vector = 32'h0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] boot_strap_pins,
   input wire logic [1:0] core_ratio_strap_pins,
   input wire logic [1:0] boot_mode,
   input wire logic [5:0] pll_multiplier,
   input wire logic core_run,
   input wire logic fetch_start,
   input wire logic [31:0] fetch_address,
   input wire logic clock_pin_out,
   input wire logic clock_pin_oe_n,
   input wire logic running_reset,
   input wire logic [3:0] flag_pin_oe_n,
   input wire logic [31:0] data_pin_out,
   input wire logic [31:0] data_pin_oe_n,
   input wire logic [31:0] external_port_data_out,
   input wire logic external_port_data_drive,
   input wire logic [2:0] data_mode
);
   int cnt; // Edges since reset release, saturating
   // Count edges after release so the lock wait can be timed
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
      end else if (cnt < lock_wait + 4) begin
         cnt <= cnt + 1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   chk_strap_latch: assert property (
      $fell(rst) |=> boot_mode == boot_strap_pins && pll_multiplier == (core_ratio_strap_pins
      == 2'h1 ? 6'h20 : core_ratio_strap_pins == 2'h2 ? 6'h10 : 6'h06))
      else $error("strap latch wrong");
   chk_reset_state: assert property (
      $fell(rst) |-> data_mode == 3'h0 && !clock_pin_oe_n && !clock_pin_out)
      else $error("state after reset wrong");
   chk_flag_hiz: assert property (
      $fell(rst) |-> (flag_pin_oe_n == 4'hf) [*3])
      else $error("flag pins driven early");
   chk_lock_early: assert property (
      cnt <= lock_wait |-> !core_run)
      else $error("core ran before lock wait");
   chk_lock_late: assert property (
      cnt == lock_wait + 1 |-> core_run)
      else $error("core late after lock wait");
   chk_fetch_vector: assert property (
      $rose(core_run) |-> fetch_start && fetch_address == vector ##1 !fetch_start)
      else $error("fetch start wrong");
   chk_run_reset: assert property (
      running_reset |-> clock_pin_oe_n ##1 !core_run)
      else $error("running reset ignored");
   chk_mode_tristate: assert property (
      data_mode == 3'h7 && $past(data_mode) == 3'h7 |-> data_pin_oe_n == 32'hffff_ffff)
      else $error("pins driven in tri-state mode");
   chk_port_data: assert property (
      cnt > 2 && data_mode == 3'h0 && $past(data_mode) == 3'h0 && $past(external_port_data_drive)
      |-> data_pin_out == $past(external_port_data_out) && data_pin_oe_n == 32'h0)
      else $error("port data not on pins");
endmodule

//--- strap_pin_pkg.sv
// Constants for the start-up strap and pin function multiplexer
package strap_pin_pkg;

   // ****************************************************************
   // Register byte offsets
   // ****************************************************************
   localparam logic [5:0] off_system_control = 6'h00; // Data pin mode and group select
   localparam logic [5:0] off_power_management = 6'h04; // Multiplier, divider, pin clock
   localparam logic [5:0] off_running_reset = 6'h08; // Running reset enable
   localparam logic [5:0] off_flag_control = 6'h0c; // Flag pin drive
   localparam logic [5:0] off_status = 6'h10; // Read-only state

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int mode_lsb = 0; // Data pin mode, 3 bits
   localparam int group_lsb = 4; // Flag/PWM group select, 4 bits
   localparam int mult_lsb = 0; // PLL multiplier, 6 bits
   localparam int div_lsb = 6; // PLL divider, 2 bits
   localparam int clk_sel_bit = 12; // Pin drives PLL clock instead of reset out
   localparam int run_reset_bit = 0; // Pin becomes running reset input
   localparam int flag_out_lsb = 0; // Flag output levels, 4 bits
   localparam int flag_drive_lsb = 4; // Flag output enables, 4 bits

   // ****************************************************************
   // Data pin modes
   // ****************************************************************
   localparam logic [2:0] mode_port_all = 3'h0; // All pins external port data
   localparam logic [2:0] mode_flags_upper = 3'h1; // Flags/PWM on 31-16
   localparam logic [2:0] mode_flags_mid = 3'h2; // Plus flags on 15-8
   localparam logic [2:0] mode_flags_all = 3'h3; // All flags
   localparam logic [2:0] mode_acq_port = 3'h4; // Acquisition port, port data low byte
   localparam logic [2:0] mode_acq_flags = 3'h5; // Acquisition port, flags low byte
   localparam logic [2:0] mode_reserved = 3'h6; // Must not be selected
   localparam logic [2:0] mode_tristate = 3'h7; // All pins high-impedance

   // ****************************************************************
   // Strap codes and values
   // ****************************************************************
   localparam logic [1:0] boot_spi_slave = 2'h0;
   localparam logic [1:0] boot_spi_master = 2'h1;
   localparam logic [1:0] boot_ext_memory = 2'h2;
   localparam logic [1:0] strap_reserved = 2'h3;
   localparam logic [1:0] ratio_code_6 = 2'h0;
   localparam logic [1:0] ratio_code_32 = 2'h1;
   localparam logic [1:0] ratio_code_16 = 2'h2;
   localparam logic [5:0] mult_6 = 6'h06;
   localparam logic [5:0] mult_32 = 6'h20;
   localparam logic [5:0] mult_16 = 6'h10;

   // ****************************************************************
   // Reset values and counts
   // ****************************************************************
   localparam logic [2:0] mode_reset = 3'h0; // Port data after reset
   localparam logic [1:0] div_reset = 2'h0;
   localparam int lock_cycles = 4096; // Reference clock cycles for PLL lock
   localparam logic [31:0] reset_vector = 32'h0008_0000; // Arbitrary default vector

endpackage

//--- test_strap_pin_mux.sv
// Self-checking bench for the strap and pin function multiplexer
`timescale 1ns/1ps
module test_strap_pin_mux;
   localparam int lw = 16; // Shortened lock wait
   localparam logic [31:0] vec = 32'h0000_0100;
   localparam logic [31:0] ep = 32'ha5c3_0f96;
   localparam logic [15:0] uf = 16'h1234;
   localparam logic [15:0] pw = 16'hcafe;
   localparam logic [15:0] lf = 16'h5678;
   localparam logic [31:0] bd = 32'h3c5a_96e1;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, fetch_address, data_pin_in, data_pin_out, data_pin_oe_n;
   logic [31:0] external_port_data_in;
   logic [31:0] external_port_data_out = ep;
   logic [31:0] board_data = bd;
   logic [15:0] upper_flag_out = uf, pwm_out = pw, lower_flag_out = lf;
   logic [15:0] upper_flag_drive = 16'hffff, lower_flag_drive = 16'hffff;
   logic external_port_data_drive = 1'b1, pll_clock_level = 1'b0, run_low = 1'b0;
   logic [1:0] boot_strap_pins = 2'h0, core_ratio_strap_pins = 2'h0, boot_mode, pll_divider;
   logic [5:0] pll_multiplier;
   logic avs_waitrequest, core_run, fetch_start, clock_pin_in, clock_pin_out, clock_pin_oe_n;
   logic running_reset;
   logic [3:0] flag_pin_in, flag_pin_out, flag_pin_oe_n;
   logic [23:0] parallel_acquisition_port;
   logic [2:0] data_mode;
   int fail_count = 0;
   int num_checks = 0;
   strap_pin_mux #(.lock_wait(lw), .vector(vec)) u_strap_pin_mux (.*);
   board_model u_board_model (.*);
   // Compare one value, report and count a mismatch
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      if (n >= 50) fail_count++;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // Register write without read data
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   // Reset with both straps set to one code and time the start-up
   task automatic boot(input logic [1:0] code);
      int n;
      boot_strap_pins <= code;
      core_ratio_strap_pins <= code;
      @(posedge clk);
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      n = 0;
      while (core_run !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      check("cycles to run", lw + 2, n);
      check("fetch start", 1, fetch_start);
      check("fetch address", vec, fetch_address);
      check("boot mode", code, boot_mode);
      check("multiplier", code == 1 ? 32 : code == 2 ? 16 : 6, pll_multiplier);
      check("data mode", 0, data_mode);
      check("flag enables", 4'hf, flag_pin_oe_n);
      @(posedge clk);
      check("fetch pulse end", 0, fetch_start);
      check("reset out", 1, {clock_pin_oe_n, clock_pin_out});
      $display("test boot %0d done", code);
   endtask
   // Every data pin mode but the reserved one, then the PWM groups
   task automatic modes;
      logic [31:0] eo, en;
      for (int m = 0; m < 8; m++) begin
         if (m == 6) continue;
         wr(6'h00, m);
         repeat (7) @(posedge clk);
         en = 32'h0;
         case (m)
            0: eo = ep;
            1: eo = {uf, ep[15:0]};
            2: eo = {uf, lf[15:8], ep[7:0]};
            3: eo = {uf, lf};
            4: begin eo = {24'h0, ep[7:0]}; en = 32'hffff_ff00; end
            5: begin eo = {24'h0, lf[7:0]}; en = 32'hffff_ff00; end
            default: begin eo = 32'h0; en = 32'hffff_ffff; end
         endcase
         check("pin enables", en, data_pin_oe_n);
         check("pin data", eo & ~en, data_pin_out & ~en);
         if (m == 4 || m == 5) check("acq port", bd[31:8], parallel_acquisition_port);
      end
      wr(6'h00, 32'h0000_00a1);
      repeat (3) @(posedge clk);
      check("pwm groups", {pw[15:12], uf[11:8], pw[7:4], uf[3:0]}, data_pin_out[31:16]);
      $display("test modes done");
   endtask
   // Software clock setting, clock pin, running reset and flag pins
   task automatic controls;
      logic [31:0] q;
      wr(6'h04, 32'h0000_004b);
      repeat (2) @(posedge clk);
      check("sw multiplier", 6'h0b, pll_multiplier);
      check("sw divider", 2'h1, pll_divider);
      wr(6'h04, 32'h0000_104b);
      pll_clock_level <= 1'b1;
      repeat (3) @(posedge clk);
      check("clock pin high", 2'b01, {clock_pin_oe_n, clock_pin_out});
      pll_clock_level <= 1'b0;
      repeat (3) @(posedge clk);
      check("clock pin low", 2'b00, {clock_pin_oe_n, clock_pin_out});
      wr(6'h08, 32'h1);
      repeat (3) @(posedge clk);
      check("pin released", 1, clock_pin_oe_n);
      run_low <= 1'b1;
      repeat (8) @(posedge clk);
      check("held in reset", 2'b10, {running_reset, core_run});
      run_low <= 1'b0;
      repeat (8) @(posedge clk);
      check("running again", 2'b01, {running_reset, core_run});
      bus(1'b0, 6'h10, 32'h0, q);
      check("status straps", 4'ha, q[3:0]);
      check("status flags", 4'h9, q[11:8]);
      check("override", 1, q[12]);
      wr(6'h0c, 32'h0000_00f5);
      repeat (2) @(posedge clk);
      check("flag pins", 8'h05, {flag_pin_oe_n, flag_pin_out});
      bus(1'b0, 6'h14, 32'h0, q);
      check("unmapped read", 0, q);
      $display("test controls done");
   endtask
   // Print the counts and the verdict, then stop
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Free-running reference clock
   initial begin
      forever #5 clk = ~clk;
   end
   // Main sequence
   initial begin
      for (int c = 0; c < 3; c++) boot(2'(c));
      modes;
      controls;
      conclude;
   end
   // Watchdog against a hang
   initial begin
      #50000;
      fail_count++;
      conclude;
   end
endmodule
bind strap_pin_mux strap_pin_mux_checker #(.lock_wait(lock_wait), .vector(vector))
   u_chk (.*);
